// ==== hw/scc_formatter.sv ====
`timescale 1ns/1ps
// How it works
// [RULE1] Spreading factor is 256 shifted right by k, k from 0 to 6.
// [RULE2] Bits per slot are 20 shifted left by k; sixteen slots per frame.
// [RULE3] Pilot field size is configurable; spreading factor 64 default gives 72 data, 8 pilot.
// [RULE4] Pilot symbols outside the sync word are sent as 11.
// [RULE5] Pilot symbols 1 and 3 follow the per-slot table; 0 and 2 are 11.
// [RULE6] Pilot symbols leave in ascending index order, symbol 0 first.
// [RULE7] First bit of each pair drives I, second drives Q.
// [RULE8] Each burst starts with a preamble shaped like slot 16 pilots.
// [RULE9] Scrambler phase restarts at the preamble and runs on into the burst.
// [RULE10] Nothing is sent unless data is queued at burst start or frame end.
// [RULE11] One instance carries only paging or only forward access data.
// [RULE12] No power control field exists in the slot.
// [RULE13] Rate and spreading factor stay constant and are exported for broadcast.
// [RULE14] Slot counter runs 1 to 16 and wraps at the frame boundary.
module scc_formatter (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [scc_pkg::K_W-1:0] cfg_k,
  input wire logic [scc_pkg::SYM_W-1:0] cfg_pilot_syms,
  input wire logic cfg_chan_pch,
  input wire logic d_valid,
  input wire logic [1:0] d_sym,
  output logic d_ready,
  output logic sym_valid,
  output logic sym_i,
  output logic sym_q,
  output logic sym_pilot,
  output logic sym_preamble,
  output logic sym_dtx,
  output logic [scc_pkg::SLOT_W-1:0] slot_num,
  output logic frame_start,
  output logic scr_phase_clear,
  output logic tx_on,
  output logic [scc_pkg::SF_W-1:0] bcast_sf,
  output logic [scc_pkg::BITS_W-1:0] bcast_slot_bits,
  output logic bcast_chan_pch
);
  import scc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration, frozen for the whole burst
  scc_state_type state_r, state_nxt;
  logic [K_W-1:0] k_r;
  logic [SYM_W-1:0] npilot_r;
  logic pch_r;
  logic [SYM_W-1:0] cnt_r, cnt_nxt;
  logic [SLOT_W-1:0] slot_r, slot_nxt;

  wire logic [K_W-1:0] k_clamp = (cfg_k > K_MAX) ? K_MAX : cfg_k;

  // [RULE11] [RULE13] config locked outside idle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      k_r <= K_SF64;
      npilot_r <= PILOT_SYMS_SF64;
      pch_r <= 1'b0;
    end else if (state_r == ST_IDLE) begin
      k_r <= k_clamp;
      npilot_r <= cfg_pilot_syms;
      pch_r <= cfg_chan_pch;
    end
  end

  // [RULE1] spreading factor derivation
  assign bcast_sf = SF_BASE >> k_r;
  // [RULE2] bits per slot
  assign bcast_slot_bits = SLOT_BITS_BASE << k_r;
  assign bcast_chan_pch = pch_r;

  ////////////////////////////////////////////////////////////////////////////
  // Slot geometry
  wire logic [SYM_W-1:0] slot_syms = SLOT_SYMS_BASE << k_r;
  // [RULE3] configurable pilot field, clamped into the slot
  wire logic [SYM_W-1:0] npilot_eff = (npilot_r < PILOT_SYMS_MIN) ? PILOT_SYMS_MIN :
                                      (npilot_r > slot_syms) ? slot_syms : npilot_r;
  wire logic [SYM_W-1:0] data_syms = slot_syms - npilot_eff;
  wire logic in_run = (state_r == ST_RUN);
  wire logic in_pre = (state_r == ST_PRE);
  wire logic pos_data = in_run && (cnt_r < data_syms);
  wire logic pos_pilot = in_pre || (in_run && !pos_data);
  wire logic slot_end = (cnt_r == slot_syms - PILOT_SYMS_MIN);
  wire logic pre_end = (cnt_r == npilot_eff - PILOT_SYMS_MIN);
  wire logic frame_end = in_run && slot_end && (slot_r == SLOT_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // Pilot lookup
  scc_pilot_if pil ();
  // [RULE8] preamble reuses the slot 16 pattern
  assign pil.slot = in_pre ? SLOT_LAST : slot_r;
  // [RULE6] pilot index ascends with the symbol counter
  assign pil.idx = in_pre ? cnt_r : (cnt_r - data_syms);

  scc_pilot_rom u_rom (
    .p(pil)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Burst sequencer
  // [RULE10] data drawn only in data positions of a running burst
  assign d_ready = pos_data;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    slot_nxt = slot_r;
    case (state_r)
      ST_IDLE: begin
        cnt_nxt = '0;
        slot_nxt = SLOT_FIRST;
        // [RULE10] a burst opens only when data waits
        if (d_valid) begin
          state_nxt = ST_PRE;
        end
      end
      ST_PRE: begin
        if (pre_end) begin
          state_nxt = ST_RUN;
          cnt_nxt = '0;
        end else begin
          cnt_nxt = cnt_r + PILOT_SYMS_MIN;
        end
      end
      ST_RUN: begin
        if (slot_end) begin
          cnt_nxt = '0;
          // [RULE14] slot wrap at frame end
          if (slot_r == SLOT_LAST) begin
            slot_nxt = SLOT_FIRST;
            // [RULE10] burst stays whole frames, ends when queue is empty
            if (!d_valid) begin
              state_nxt = ST_IDLE;
            end
          end else begin
            slot_nxt = slot_r + SLOT_FIRST;
          end
        end else begin
          cnt_nxt = cnt_r + PILOT_SYMS_MIN;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
      slot_r <= SLOT_FIRST;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      slot_r <= slot_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Symbol output; an underrun mid-burst sends a blank symbol to keep slot timing
  // [RULE12] slot carries only data and pilot, no power control field
  wire logic dtx_now = pos_data && !d_valid;
  wire logic [1:0] pair_now = pos_data ? (d_valid ? d_sym : PAIR_ZERO) : pil.pair;

  // [RULE7] pair high bit on I, low bit on Q
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sym_valid <= 1'b0;
      sym_i <= 1'b0;
      sym_q <= 1'b0;
      sym_pilot <= 1'b0;
      sym_preamble <= 1'b0;
      sym_dtx <= 1'b0;
      slot_num <= SLOT_FIRST;
      frame_start <= 1'b0;
      scr_phase_clear <= 1'b0;
    end else begin
      sym_valid <= (state_r != ST_IDLE);
      sym_i <= pair_now[1];
      sym_q <= pair_now[0];
      sym_pilot <= pos_pilot;
      sym_preamble <= in_pre;
      sym_dtx <= dtx_now;
      slot_num <= pil.slot;
      frame_start <= in_run && (cnt_r == '0) && (slot_r == SLOT_FIRST);
      // [RULE9] single phase restart at preamble head, none at the first frame start
      scr_phase_clear <= in_pre && (cnt_r == '0);
    end
  end

  assign tx_on = sym_valid;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_ones;
    sym_i && sym_q;
  endsequence
  sequence s_zero;
    !sym_i && !sym_q;
  endsequence

  property p_sf_range;
    @(posedge clk_sys) disable iff (srst)
      (bcast_sf <= SF_BASE) && (bcast_sf >= (SF_BASE >> K_MAX)) && (bcast_sf == (SF_BASE >> k_r));
  endproperty
  a_sf_range: assert property (p_sf_range) else $error("spreading factor out of range"); // [RULE1]

  property p_bits_sf;
    @(posedge clk_sys) disable iff (srst)
      (32'(bcast_sf) * 32'(bcast_slot_bits)) == SF_BITS_PRODUCT;
  endproperty
  a_bits_sf: assert property (p_bits_sf) else $error("bits per slot do not match spreading factor"); // [RULE2]

  property p_sf64_split;
    @(posedge clk_sys) disable iff (srst)
      (in_run && k_r == K_SF64 && npilot_r == PILOT_SYMS_SF64 && pos_pilot && !$past(pos_pilot))
        |-> (cnt_r == DATA_SYMS_SF64);
  endproperty
  a_sf64_split: assert property (p_sf64_split) else $error("slot split at SF 64 wrong"); // [RULE3]

  property p_plain_pilot;
    @(posedge clk_sys) disable iff (srst)
      (pos_pilot && pil.idx != PILOT_IDX_ODD1 && pil.idx != PILOT_IDX_ODD3) |=> s_ones;
  endproperty
  a_plain_pilot: assert property (p_plain_pilot) else $error("plain pilot symbol not 11"); // [RULE4]

  property p_slot1_pilot;
    @(posedge clk_sys) disable iff (srst)
      ($rose(sym_pilot) && !sym_preamble && slot_num == SLOT_FIRST && npilot_r == PILOT_SYMS_SF64)
        |-> s_ones ##1 s_ones ##1 s_ones ##1 s_ones;
  endproperty
  a_slot1_pilot: assert property (p_slot1_pilot) else $error("slot 1 pilot pattern wrong"); // [RULE5]

  property p_preamble;
    @(posedge clk_sys) disable iff (srst)
      (scr_phase_clear && npilot_r == PILOT_SYMS_SF64)
        |-> s_ones ##1 s_zero ##1 s_ones ##1 (s_zero and sym_preamble);
  endproperty
  a_preamble: assert property (p_preamble) else $error("preamble differs from slot 16 pilots"); // [RULE8]

  // Rest of the preamble, with no second phase restart
  sequence s_pre_tail;
    (sym_valid && sym_preamble && !scr_phase_clear)[*3];
  endsequence

  property p_phase_run;
    @(posedge clk_sys) disable iff (srst)
      (scr_phase_clear && npilot_r == PILOT_SYMS_SF64)
        |=> s_pre_tail ##1 (frame_start && sym_valid && !sym_preamble && !scr_phase_clear);
  endproperty
  a_phase_run: assert property (p_phase_run) else $error("burst does not follow preamble directly"); // [RULE9]

  property p_quiet;
    @(posedge clk_sys) disable iff (srst)
      (state_r == ST_IDLE && !d_valid) |=> !sym_valid && !d_ready;
  endproperty
  a_quiet: assert property (p_quiet) else $error("transmission without queued data"); // [RULE10]

  property p_iq_map;
    @(posedge clk_sys) disable iff (srst)
      (d_valid && d_ready) |=> (sym_i == $past(d_sym[1])) && (sym_q == $past(d_sym[0])) && !sym_pilot;
  endproperty
  a_iq_map: assert property (p_iq_map) else $error("data pair mapped to wrong rail"); // [RULE7]

  property p_cfg_hold;
    @(posedge clk_sys) disable iff (srst)
      (tx_on && $past(tx_on)) |-> $stable(bcast_chan_pch) && $stable(bcast_sf);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("channel config changed in a burst"); // [RULE13]

  property p_slot_wrap;
    @(posedge clk_sys) disable iff (srst)
      frame_end |=> (slot_r == SLOT_FIRST) ##1 (!sym_valid || (frame_start && slot_num == SLOT_FIRST));
  endproperty
  a_slot_wrap: assert property (p_slot_wrap) else $error("slot counter did not wrap"); // [RULE14]
endmodule : scc_formatter

// ==== hw/scc_pkg.sv ====
package scc_pkg;
  // Spreading factor and slot geometry
  localparam int K_W = 3;
  localparam logic [K_W-1:0] K_MAX = 3'h6;
  localparam int SF_W = 9;
  localparam logic [SF_W-1:0] SF_BASE = 9'h100;
  localparam int BITS_W = 11;
  localparam logic [BITS_W-1:0] SLOT_BITS_BASE = 11'h014;
  localparam int SF_BITS_PRODUCT = 5120;
  localparam int SYM_W = 10;
  localparam logic [SYM_W-1:0] SLOT_SYMS_BASE = 10'h00a;
  localparam logic [SYM_W-1:0] PILOT_SYMS_MIN = 10'h001;
  localparam logic [SYM_W-1:0] PILOT_SYMS_SF64 = 10'h004;
  localparam logic [SYM_W-1:0] DATA_SYMS_SF64 = 10'h024;
  localparam logic [K_W-1:0] K_SF64 = 3'h2;
  // Slot numbering runs 1..16 within a radio frame
  localparam int SLOT_W = 5;
  localparam logic [SLOT_W-1:0] SLOT_FIRST = 5'h01;
  localparam logic [SLOT_W-1:0] SLOT_LAST = 5'h10;
  // Pilot pairs; symbol 1 and 3 tables, two bits per slot, slot 1 in the low bits
  localparam logic [1:0] PAIR_ONES = 2'h3;
  localparam logic [1:0] PAIR_ZERO = 2'h0;
  localparam logic [SYM_W-1:0] PILOT_IDX_ODD1 = 10'h001;
  localparam logic [SYM_W-1:0] PILOT_IDX_ODD3 = 10'h003;
  localparam logic [31:0] PILOT_TAB_SYM1 = 32'h1877_9a9f;
  localparam logic [31:0] PILOT_TAB_SYM3 = 32'h0164_4f57;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_PRE = 2'h1,
    ST_RUN = 2'h3
  } scc_state_type;
endpackage : scc_pkg

// ==== hw/scc_pilot_if.sv ====
`timescale 1ns/1ps
interface scc_pilot_if;
  logic [scc_pkg::SLOT_W-1:0] slot;
  logic [scc_pkg::SYM_W-1:0] idx;
  logic [1:0] pair;
  modport rom (input slot, input idx, output pair);
  modport user (output slot, output idx, input pair);
endinterface : scc_pilot_if

// ==== hw/scc_pilot_rom.sv ====
`timescale 1ns/1ps
module scc_pilot_rom (
  scc_pilot_if.rom p
);
  import scc_pkg::*;

  wire logic [SLOT_W-1:0] slot_m1 = p.slot - SLOT_FIRST;
  wire logic [SLOT_W-1:0] bit_pos = {slot_m1[3:0], 1'b0};
  wire logic [1:0] pair_sym1 = PILOT_TAB_SYM1[bit_pos +: 2];
  wire logic [1:0] pair_sym3 = PILOT_TAB_SYM3[bit_pos +: 2];

  // [RULE4] [RULE5] plain pilots, per-slot table
  // Symbols 0, 2 and any beyond symbol 3 stay at all ones; only 1 and 3 are patterned
  assign p.pair = (p.idx == PILOT_IDX_ODD1) ? pair_sym1 :
                  (p.idx == PILOT_IDX_ODD3) ? pair_sym3 : PAIR_ONES;
endmodule : scc_pilot_rom

// ==== tb/scc_rx_model.sv ====
`timescale 1ns/1ps
module scc_rx_model (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic sym_valid,
  input wire logic frame_start,
  input wire logic scr_phase_clear,
  output int rx_frames,
  output int rx_phase_err
);
  logic in_burst = 1'b0;
  always @(posedge clk_sys) begin
    if (srst) begin
      rx_frames <= 0;
      rx_phase_err <= 0;
      in_burst <= 1'b0;
    end else begin
      in_burst <= (sym_valid === 1'b1);
      // descrambler restarts only at burst head
      if ((sym_valid === 1'b1) && ((scr_phase_clear === 1'b1) == in_burst)) begin
        rx_phase_err <= rx_phase_err + 1;
      end
      if (scr_phase_clear === 1'b1) begin
        rx_frames <= 0;
      end
      if ((sym_valid === 1'b1) && (frame_start === 1'b1)) begin
        rx_frames <= rx_frames + 1;
      end
    end
  end
endmodule : scc_rx_model

// ==== tb/scc_formatter_tb.sv ====
`timescale 1ns/1ps
module scc_formatter_tb;
  import scc_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [K_W-1:0] cfg_k = 3'h2;
  logic [SYM_W-1:0] cfg_pilot_syms = 10'h004;
  logic cfg_chan_pch = 1'b0;
  logic d_valid = 1'b0;
  logic [1:0] d_sym = 2'h0;
  logic d_ready, sym_valid, sym_i, sym_q, sym_pilot, sym_preamble, sym_dtx, frame_start, scr_phase_clear, tx_on;
  logic [SLOT_W-1:0] slot_num;
  logic [SF_W-1:0] bcast_sf;
  logic [BITS_W-1:0] bcast_slot_bits;
  logic bcast_chan_pch;
  int rx_frames, rx_phase_err;
  int err_count = 0;
  int n_compared = 0;
  // Expected burst shape, set while the design is idle
  int ek, np, ss, nf, pos = -1;
  logic ech;
  logic [1:0] dq [$];
  int t1 [16] = '{3, 3, 1, 2, 2, 2, 1, 2, 3, 1, 3, 1, 0, 2, 1, 0};
  int t3 [16] = '{3, 1, 1, 1, 3, 3, 0, 1, 0, 1, 2, 1, 1, 0, 0, 0};

  always #5 clk_sys = ~clk_sys;

  scc_formatter i_dut (.clk_sys(clk_sys), .srst(srst), .cfg_k(cfg_k), .cfg_pilot_syms(cfg_pilot_syms),
    .cfg_chan_pch(cfg_chan_pch), .d_valid(d_valid), .d_sym(d_sym), .d_ready(d_ready), .sym_valid(sym_valid),
    .sym_i(sym_i), .sym_q(sym_q), .sym_pilot(sym_pilot), .sym_preamble(sym_preamble), .sym_dtx(sym_dtx),
    .slot_num(slot_num), .frame_start(frame_start), .scr_phase_clear(scr_phase_clear), .tx_on(tx_on),
    .bcast_sf(bcast_sf), .bcast_slot_bits(bcast_slot_bits), .bcast_chan_pch(bcast_chan_pch));

  scc_rx_model i_rx (.clk_sys(clk_sys), .srst(srst), .sym_valid(sym_valid), .frame_start(frame_start),
    .scr_phase_clear(scr_phase_clear), .rx_frames(rx_frames), .rx_phase_err(rx_phase_err));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input string name, input logic [23:0] e, input logic [23:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, e, g);
    end
  endtask : cmp

  task automatic summarize();
    if (err_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize

  function automatic logic [1:0] pil(input int sl, input int ix);
    if (ix == 1) return 2'(t1[sl-1]);
    if (ix == 3) return 2'(t3[sl-1]);
    return 2'h3;
  endfunction : pil

  ////////////////////////////////////////////////////////////////////////////////
  // Reference stream: outputs are read as sampled at the edge, before this edge's take
  always @(posedge clk_sys) begin : ref_model
    int q, sl, ix;
    logic fs;
    logic [1:0] e;
    logic dtx;
    if (!srst) begin
      cmp("tx_on", 24'(sym_valid), 24'(tx_on));
      if (sym_valid === 1'b1) begin
        if (pos < 0) pos = 0;
        sl = 16;
        ix = pos;
        fs = 1'b0;
        if (pos >= np) begin
          q = pos - np;
          sl = (q / ss) % 16 + 1;
          ix = q % ss - (ss - np);
          fs = (q % ss == 0) && (sl == 1);
        end
        if (ix < 0) begin
          dtx = (dq.size() == 0);
          e = dtx ? 2'h0 : dq.pop_front();
          cmp("data", 24'({e, 2'b00, dtx}), 24'({sym_i, sym_q, sym_pilot, sym_preamble, sym_dtx}));
        end else begin
          e = pil(sl, ix);
          cmp("pilot", 24'({e, 1'b1, pos < np, 1'b0}),
            24'({sym_i, sym_q, sym_pilot, sym_preamble, sym_dtx}));
        end
        cmp("framing", 24'({5'(sl), fs, pos == 0}), 24'({slot_num, frame_start, scr_phase_clear}));
        // Config inputs wander during the burst, so this shows the frozen copy
        cmp("bcast", 24'({9'(256 >> ek), 11'(20 << ek), ech}),
          24'({bcast_sf, bcast_slot_bits, bcast_chan_pch}));
        pos++;
      end else if (pos >= 0) begin
        cmp("length", 24'(np + nf * 16 * ss), 24'(pos));
        cmp("frames", 24'(nf), 24'(rx_frames));
        cmp("phase", 24'(0), 24'(rx_phase_err));
        pos = -1;
      end
      if ((d_valid === 1'b1) && (d_ready === 1'b1)) dq.push_back(d_sym);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Underruns only away from the frame end, so the burst length stays predictable
  task automatic burst(input int k, input int npl, input int frames);
    int n;
    @(posedge clk_sys);
    #1;
    cfg_k = 3'(k);
    cfg_pilot_syms = 10'(npl);
    cfg_chan_pch = 1'($urandom);
    ek = (k > 6) ? 6 : k;
    np = (npl < 1) ? 1 : npl;
    ss = 10 << ek;
    nf = frames;
    ech = cfg_chan_pch;
    @(posedge clk_sys);
    #1;
    d_valid = 1'b1;
    n = 0;
    while (!(rx_frames == frames && slot_num == 5'h08) && n < 30000) begin
      @(posedge clk_sys);
      #1;
      d_sym = 2'($urandom);
      d_valid = (slot_num < 5'h02) || (slot_num > 5'h0e) || ($urandom % 4 != 0);
      cfg_k = 3'($urandom);
      cfg_pilot_syms = 10'($urandom);
      cfg_chan_pch = 1'($urandom);
      n++;
    end
    cmp("timeout", 24'(0), 24'(n >= 30000));
    d_valid = 1'b0;
    n = 0;
    while (sym_valid !== 1'b0 && n < 30000) begin
      @(posedge clk_sys);
      n++;
    end
    cmp("timeout", 24'(0), 24'(n >= 30000));
    repeat (20) begin
      @(posedge clk_sys);
      cmp("idle", 24'(0), 24'(sym_valid));
    end
  endtask : burst

  initial begin
    void'($urandom(2302));
    repeat (16) @(posedge clk_sys);
    #1;
    srst = 1'b0;
    cmp("reset", 24'({slot_num, d_ready, sym_valid, bcast_sf}), 24'({5'h01, 2'h0, 9'h040}));
    burst(2, 4, 2);
    for (int k = 0; k < 8; k++) begin
      burst(k, k, 1);
    end
    summarize();
  end

  initial begin
    #800000;
    err_count++;
    summarize();
  end
endmodule : scc_formatter_tb
